// ### rtt_ctrl.sv
// rtt_ctrl: controller end, registers, command timing, data bursts, read buffer
// assumes one device on the link and software that polls the status register
// Operation
// - burst field 00 gives eight beats
// - field 01, select low gives four beats
// - field 10 gives fixed four beats
// - burst select sampled on every command
// - read data after cas plus additive latency
// - two-clock preamble raises column write latency
// - read to close: additive plus read-to-close
// - read-to-close at least four clocks, 7.5ns
// - close only after activate-to-close minimum
// - reopen after precharge period from close
// - reopen after row cycle minimum too
// - auto close bit closes bank after read
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rtt_ctrl (
  input  wire logic        clk_i,        // 100 MHz clock
  input  wire logic        rst_n_i,      // synchronous reset, active low
  rtt_if.ctrl              link,         // command and data bus
  input  wire logic [7:0]  reg_addr_i,   // register byte address
  input  wire logic [31:0] reg_wdata_i,  // register write data
  input  wire logic        reg_wr_i,     // write strobe
  input  wire logic        reg_rd_i,     // read strobe
  output logic      [31:0] reg_rdata_o,  // read data, cycle after strobe
  output logic      [7:0]  rd_data_o,    // read word out
  output logic             rd_valid_o,   // read word valid
  input  wire logic        rd_ready_i    // read word taken
);

  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_WAIT = 2'h1, ST_MODE = 2'h3} rtt_st_t;

  rtt_st_t    st_r;
  logic [1:0] cfg_bl_r, cfg_al_r;
  logic [4:0] cfg_cl_r;
  logic [3:0] cfg_cwl_r;
  logic       cfg_pre2_r;
  logic [2:0] p_op_r, p_col_r;
  logic       p_bank_r, p_bsel_r, p_ap_r;
  logic [7:0] wseed_r;
  logic [6:0] ras_r [2], rc_r [2], rp_r [2], rtp_r [2];
  logic [1:0] open_r;
  logic [6:0] rd_busy_r;
  logic [5:0] cap_cnt_r, drv_cnt_r;
  logic [3:0] cap_left_r, drv_left_r, st_fill_r, st_take_r;
  logic [2:0] drv_idx_r;
  logic [7:0] st_mem_r [8];
  logic [7:0] sk_d_r;
  logic       sk_v_r;
  logic [3:0] cwl_eff, beats_w;
  logic [5:0] al_w, rl_w, wl_w;
  logic       cwl_warn, cap_fire, drv_fire, st_empty, feed_v, buf_go;
  logic       ok, issue, idle_bus;
  logic [7:0] iss;

  ////////////////////////////////////////////////////////////////////////////
  // raise column_write_latency under two-clock preamble
  assign cwl_warn = cfg_pre2_r && (cfg_cwl_r < rtt_pkg::CWL_MIN + 4'h1);
  assign cwl_eff  = cwl_warn ? rtt_pkg::CWL_MIN + 4'h1 : cfg_cwl_r;
  assign al_w     = rtt_pkg::al_of(cfg_cl_r, cfg_al_r);
  assign rl_w     = 6'(cfg_cl_r) + al_w;
  assign wl_w     = 6'(cwl_eff) + al_w;
  assign beats_w  = rtt_pkg::beats_of(cfg_bl_r, p_bsel_r);
  assign cap_fire = (cap_left_r != 4'h0) && (cap_cnt_r <= 6'h01);
  assign drv_fire = (drv_left_r != 4'h0) && (drv_cnt_r <= 6'h01);
  assign st_empty = (st_fill_r == st_take_r);
  assign idle_bus = (cap_left_r == 4'h0) && (drv_left_r == 4'h0) && st_empty;

  // legality of the pending command against per-bank timers
  always_comb
  begin
    ok = 1'b1;
    unique case (p_op_r)
      3'(rtt_pkg::CMD_ACT): ok = !open_r[p_bank_r] && rp_r[p_bank_r] == 7'h00
                                 && rc_r[p_bank_r] == 7'h00;
      // close after read and activate windows
      3'(rtt_pkg::CMD_PRE): ok = open_r[p_bank_r] && ras_r[p_bank_r] == 7'h00
                                 && rtp_r[p_bank_r] == 7'h00;
      3'(rtt_pkg::CMD_RD):  ok = open_r[p_bank_r] && idle_bus;
      // write data after read burst and postamble
      3'(rtt_pkg::CMD_WR):  ok = open_r[p_bank_r] && drv_left_r == 4'h0
                                 && 7'(rd_busy_r) + (cfg_pre2_r ? 7'h02 : 7'h01)
                                    <= 7'(wl_w);
      default:              ok = 1'b1;
    endcase
  end
  assign issue = (st_r == ST_WAIT) && ok;
  // one-hot of the command issued this cycle
  assign iss   = issue ? 8'h01 << p_op_r : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // register writes and command state; config and command writes outside idle are ignored, write data writes are always taken
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r       <= ST_IDLE;
      cfg_bl_r   <= rtt_pkg::RST_BL;
      cfg_cl_r   <= rtt_pkg::RST_CL;
      cfg_al_r   <= rtt_pkg::RST_AL;
      cfg_cwl_r  <= rtt_pkg::RST_CWL;
      cfg_pre2_r <= 1'b0;
      p_op_r     <= 3'h0;
      p_col_r    <= 3'h0;
      p_bank_r   <= 1'b0;
      p_bsel_r   <= 1'b0;
      p_ap_r     <= 1'b0;
      wseed_r    <= 8'h00;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == rtt_pkg::REG_WDATA)
        wseed_r <= reg_wdata_i[7:0];
      unique case (st_r)
        ST_IDLE:
        begin
          if (reg_wr_i && reg_addr_i == rtt_pkg::REG_CFG)
          begin
            cfg_bl_r   <= reg_wdata_i[1:0];
            cfg_cl_r   <= reg_wdata_i[6:2];
            cfg_al_r   <= reg_wdata_i[8:7];
            cfg_cwl_r  <= reg_wdata_i[12:9];
            cfg_pre2_r <= reg_wdata_i[13];
            st_r       <= ST_MODE;
          end
          else if (reg_wr_i && reg_addr_i == rtt_pkg::REG_CMD)
          begin
            p_op_r   <= reg_wdata_i[2:0];
            p_bank_r <= reg_wdata_i[3];
            p_col_r  <= reg_wdata_i[6:4];
            p_bsel_r <= reg_wdata_i[7];
            p_ap_r   <= reg_wdata_i[8];
            st_r     <= ST_WAIT;
          end
        end
        ST_WAIT: if (ok) st_r <= ST_IDLE;
        // mode change only once the data bus is quiet
        ST_MODE: if (idle_bus && rd_busy_r == 7'h00) st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // command bus flops: one-cycle commands
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      link.cmd_v    <= 1'b0;
      link.cmd_op   <= rtt_pkg::CMD_NOP;
      link.cmd_bank <= 1'b0;
      link.cmd_addr <= 13'h0000;
    end
    else if (st_r == ST_MODE && idle_bus && rd_busy_r == 7'h00)
    begin
      link.cmd_v    <= 1'b1;
      link.cmd_op   <= rtt_pkg::CMD_MRS;
      link.cmd_addr <= {cwl_eff, cfg_al_r, cfg_cl_r, cfg_bl_r};
    end
    else
    begin
      link.cmd_v    <= issue;
      link.cmd_op   <= issue ? rtt_pkg::rtt_cmd_t'(p_op_r) : rtt_pkg::CMD_NOP;
      link.cmd_bank <= p_bank_r;
      link.cmd_addr <= {p_bsel_r, 1'b0, p_ap_r, 7'h00, p_col_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-bank timers, loaded one short since the command shows a cycle later
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      open_r <= 2'h0;
      for (int b = 0; b < 2; b++)
      begin
        ras_r[b] <= 7'h00;
        rc_r[b]  <= 7'h00;
        rp_r[b]  <= 7'h00;
        rtp_r[b] <= 7'h00;
      end
    end
    else
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (ras_r[b] != 7'h00) ras_r[b] <= ras_r[b] - 7'h01;
        if (rc_r[b] != 7'h00)  rc_r[b]  <= rc_r[b] - 7'h01;
        if (rp_r[b] != 7'h00)  rp_r[b]  <= rp_r[b] - 7'h01;
        if (rtp_r[b] != 7'h00) rtp_r[b] <= rtp_r[b] - 7'h01;
      end
      if (iss[rtt_pkg::CMD_ACT])
      begin
        open_r[p_bank_r] <= 1'b1;
        ras_r[p_bank_r]  <= 7'(rtt_pkg::N_RAS - 1);
        rc_r[p_bank_r]   <= 7'(rtt_pkg::N_RC - 1);
      end
      if (iss[rtt_pkg::CMD_PRE])
      begin
        open_r[p_bank_r] <= 1'b0;
        rp_r[p_bank_r]   <= 7'(rtt_pkg::N_RP - 1);
      end
      if (iss[rtt_pkg::CMD_RD])
      begin
        rtp_r[p_bank_r] <= 7'(al_w) + 7'(rtt_pkg::N_RTP - 1);
        // auto close counts precharge from burst end
        if (p_ap_r)
        begin
          open_r[p_bank_r] <= 1'b0;
          rp_r[p_bank_r]   <= 7'(rl_w) + 7'(beats_w) + 7'(rtt_pkg::N_RP - 1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side: bus busy tracker and capture into the burst store
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_busy_r  <= 7'h00;
      cap_cnt_r  <= 6'h00;
      cap_left_r <= 4'h0;
      st_fill_r  <= 4'h0;
    end
    else if (iss[rtt_pkg::CMD_RD])
    begin
      rd_busy_r  <= 7'(rl_w) + 7'(beats_w);
      cap_cnt_r  <= rl_w + 6'h01;
      cap_left_r <= beats_w;
      st_fill_r  <= 4'h0;
    end
    else
    begin
      if (rd_busy_r != 7'h00) rd_busy_r <= rd_busy_r - 7'h01;
      if (cap_cnt_r > 6'h01) cap_cnt_r <= cap_cnt_r - 6'h01;
      else if (cap_fire)
      begin
        cap_cnt_r  <= 6'h00;
        cap_left_r <= cap_left_r - 4'h1;
        st_fill_r  <= st_fill_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (cap_fire)
      st_mem_r[st_fill_r[2:0]] <= link.dq;
  end

  // store to two-entry buffer; the store holds a whole burst, so a stall loses nothing
  assign feed_v = !st_empty;
  assign buf_go = rd_ready_i || !rd_valid_o;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_take_r  <= 4'h0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= 8'h00;
      sk_v_r     <= 1'b0;
      sk_d_r     <= 8'h00;
    end
    else
    begin
      if (iss[rtt_pkg::CMD_RD])
        st_take_r <= 4'h0;
      else if (feed_v && !sk_v_r)
        st_take_r <= st_take_r + 4'h1;
      if (buf_go)
      begin
        rd_valid_o <= sk_v_r || feed_v;
        rd_data_o  <= sk_v_r ? sk_d_r : st_mem_r[st_take_r[2:0]];
        sk_v_r     <= 1'b0;
      end
      else if (feed_v && !sk_v_r)
      begin
        sk_v_r <= 1'b1;
        sk_d_r <= st_mem_r[st_take_r[2:0]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write data driven at write_latency, seed plus beat index
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      drv_cnt_r    <= 6'h00;
      drv_left_r   <= 4'h0;
      drv_idx_r    <= 3'h0;
      link.dq_c    <= 8'h00;
      link.dq_c_oe <= 1'b0;
    end
    else
    begin
      link.dq_c    <= drv_fire ? wseed_r + 8'(drv_idx_r) : 8'h00;
      link.dq_c_oe <= drv_fire;
      if (iss[rtt_pkg::CMD_WR])
      begin
        drv_cnt_r  <= wl_w;
        drv_left_r <= beats_w;
        drv_idx_r  <= 3'h0;
      end
      else if (drv_cnt_r > 6'h01)
        drv_cnt_r <= drv_cnt_r - 6'h01;
      else if (drv_fire)
      begin
        drv_cnt_r  <= 6'h00;
        drv_left_r <= drv_left_r - 4'h1;
        drv_idx_r  <= drv_idx_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read: data stands only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !reg_rd_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_addr_i == rtt_pkg::REG_CFG)
      reg_rdata_o <= {18'h0, cfg_pre2_r, cfg_cwl_r, cfg_al_r, cfg_cl_r, cfg_bl_r};
    else if (reg_addr_i == rtt_pkg::REG_WDATA)
      reg_rdata_o <= {24'h0, wseed_r};
    else if (reg_addr_i == rtt_pkg::REG_STAT)
      reg_rdata_o <= {25'h0, !st_empty, rd_busy_r != 7'h00, open_r, cwl_warn, st_r};
    else
      reg_rdata_o <= 32'h0000_0000;
  end

endmodule // rtt_ctrl
`default_nettype wire

// ### rtt_pkg.sv
// rtt_pkg: constants, command codes and latency helpers shared by both ends
// assumes a single 100 MHz clock and an abstract single-rate data bus
package rtt_pkg;

  // clock and timing figures
  localparam int CLK_PS     = 10000;
  localparam int T_RTP_PS   = 7500;
  localparam int N_RTP_NCK  = 4;
  localparam int T_RAS_PS   = 32000;
  localparam int T_RP_PS    = 13750;
  localparam int T_RC_PS    = 45750;
  localparam int RTP_CEIL   = (T_RTP_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_RTP      = (RTP_CEIL > N_RTP_NCK) ? RTP_CEIL : N_RTP_NCK;
  localparam int N_RAS      = (T_RAS_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_RP       = (T_RP_PS + CLK_PS - 1) / CLK_PS;
  localparam int N_RC       = (T_RC_PS + CLK_PS - 1) / CLK_PS;

  // command codes on the command bus
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_MRS = 3'h1,
    CMD_ACT = 3'h2,
    CMD_RD  = 3'h3,
    CMD_WR  = 3'h4,
    CMD_PRE = 3'h5
  } rtt_cmd_t;

  // burst-length field encodings of mode_register_zero
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;

  // mode-register field, auto close and burst select bit positions on the address bus
  localparam int MR_BL_LSB  = 0;
  localparam int MR_CL_LSB  = 2;
  localparam int MR_AL_LSB  = 7;
  localparam int MR_CWL_LSB = 9;
  localparam int A_AP       = 10;
  localparam int A_BSEL     = 12;

  // mode reset values and lowest column_write_latency setting
  localparam logic [1:0] RST_BL  = 2'h0;
  localparam logic [4:0] RST_CL  = 5'h0B;
  localparam logic [1:0] RST_AL  = 2'h0;
  localparam logic [3:0] RST_CWL = 4'h9;
  localparam logic [3:0] CWL_MIN = 4'h9;

  // controller register byte offsets
  localparam logic [7:0] REG_CFG   = 8'h00;
  localparam logic [7:0] REG_CMD   = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;

  // additive_latency: off, cas_latency minus one, cas_latency minus two
  function automatic logic [5:0] al_of(input logic [4:0] cl, input logic [1:0] sel);
    logic [5:0] r;
    r = 6'h00;
    if (sel == 2'h1) r = 6'(cl) - 6'h01;
    if (sel == 2'h2) r = 6'(cl) - 6'h02;
    return r;
  endfunction

  // beats of one burst from the burst field and burst_select_address_bit
  function automatic logic [3:0] beats_of(input logic [1:0] blf, input logic bsel);
    return (blf == BL_FIX8 || (blf == BL_OTF && bsel)) ? 4'h8 : 4'h4;
  endfunction

endpackage

// ### rtt_if.sv
// rtt_if: command bus and shared data bus between controller and device
// assumes both ends run on the same clock; the bus level is resolved here
`timescale 1ns/10ps
`default_nettype none
interface rtt_if;
  logic               cmd_v;
  rtt_pkg::rtt_cmd_t  cmd_op;
  logic               cmd_bank;
  logic [12:0]        cmd_addr;
  logic [7:0]         dq_c;
  logic               dq_c_oe;
  logic [7:0]         dq_d;
  logic               dq_d_oe;
  logic [7:0]         dq;

  // device drive wins; an undriven bus reads as zero
  assign dq = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : 8'h00);

  modport ctrl (output cmd_v, cmd_op, cmd_bank, cmd_addr, dq_c, dq_c_oe, input dq);
  modport dram (input cmd_v, cmd_op, cmd_bank, cmd_addr, dq, output dq_d, dq_d_oe);
endinterface
`default_nettype wire

// ### rtt_dram.sv
// rtt_dram: device end, mode register, bank state, read and write bursts
// assumes the controller keeps all spacing; a new burst replaces a running one
`timescale 1ns/10ps
`default_nettype none
module rtt_dram (
  input  wire logic  clk_i,        // 100 MHz clock
  input  wire logic  rst_n_i,      // synchronous reset, active low
  rtt_if.dram        link,         // command and data bus
  output logic [1:0] bank_open_o   // open flag per bank
);

  logic [1:0] mr_bl_r;
  logic [4:0] mr_cl_r;
  logic [1:0] mr_al_r;
  logic [3:0] mr_cwl_r;
  logic [7:0] mem_r [16];
  logic [5:0] rd_cnt_r, wr_cnt_r;
  logic [3:0] rd_left_r, wr_left_r;
  logic [2:0] rd_col_r, wr_col_r;
  logic       rd_bank_r, wr_bank_r, rd_ap_r;
  logic [5:0] al_w, rl_w, wl_w;
  logic [3:0] beats_w;
  logic       rd_fire, wr_fire;

  ////////////////////////////////////////////////////////////////////////////
  // read_latency composition
  assign al_w    = rtt_pkg::al_of(mr_cl_r, mr_al_r);
  assign rl_w    = 6'(mr_cl_r) + al_w;
  assign wl_w    = 6'(mr_cwl_r) + al_w;
  assign beats_w = rtt_pkg::beats_of(mr_bl_r, link.cmd_addr[rtt_pkg::A_BSEL]);
  assign rd_fire = (rd_left_r != 4'h0) && (rd_cnt_r <= 6'h01);
  assign wr_fire = (wr_left_r != 4'h0) && (wr_cnt_r <= 6'h01);

  // mode register load
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mr_bl_r  <= rtt_pkg::RST_BL;
      mr_cl_r  <= rtt_pkg::RST_CL;
      mr_al_r  <= rtt_pkg::RST_AL;
      mr_cwl_r <= rtt_pkg::RST_CWL;
    end
    else if (link.cmd_v && link.cmd_op == rtt_pkg::CMD_MRS)
    begin
      mr_bl_r  <= link.cmd_addr[rtt_pkg::MR_BL_LSB +: 2];
      mr_cl_r  <= link.cmd_addr[rtt_pkg::MR_CL_LSB +: 5];
      mr_al_r  <= link.cmd_addr[rtt_pkg::MR_AL_LSB +: 2];
      mr_cwl_r <= link.cmd_addr[rtt_pkg::MR_CWL_LSB +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read burst: first word driven read_latency cycles after the command
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_cnt_r  <= 6'h00;
      rd_left_r <= 4'h0;
      rd_col_r  <= 3'h0;
      rd_bank_r <= 1'b0;
      rd_ap_r   <= 1'b0;
    end
    else if (link.cmd_v && link.cmd_op == rtt_pkg::CMD_RD)
    begin
      rd_cnt_r  <= rl_w - 6'h01;
      rd_left_r <= beats_w;
      rd_col_r  <= link.cmd_addr[2:0];
      rd_bank_r <= link.cmd_bank;
      rd_ap_r   <= link.cmd_addr[rtt_pkg::A_AP];
    end
    else if (rd_cnt_r > 6'h01)
      rd_cnt_r <= rd_cnt_r - 6'h01;
    else if (rd_fire)
    begin
      rd_cnt_r  <= 6'h00;
      rd_left_r <= rd_left_r - 4'h1;
      rd_col_r  <= rd_col_r + 3'h1;
    end
  end

  // data pins are registered so the bus sees clean one-cycle beats
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      link.dq_d    <= 8'h00;
      link.dq_d_oe <= 1'b0;
    end
    else
    begin
      link.dq_d    <= rd_fire ? mem_r[{rd_bank_r, rd_col_r}] : 8'h00;
      link.dq_d_oe <= rd_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write burst: words captured from write_latency cycles after the command
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_cnt_r  <= 6'h00;
      wr_left_r <= 4'h0;
      wr_col_r  <= 3'h0;
      wr_bank_r <= 1'b0;
    end
    else if (link.cmd_v && link.cmd_op == rtt_pkg::CMD_WR)
    begin
      wr_cnt_r  <= wl_w;
      wr_left_r <= beats_w;
      wr_col_r  <= link.cmd_addr[2:0];
      wr_bank_r <= link.cmd_bank;
    end
    else if (wr_cnt_r > 6'h01)
      wr_cnt_r <= wr_cnt_r - 6'h01;
    else if (wr_fire)
    begin
      wr_cnt_r  <= 6'h00;
      wr_left_r <= wr_left_r - 4'h1;
      wr_col_r  <= wr_col_r + 3'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (wr_fire)
      mem_r[{wr_bank_r, wr_col_r}] <= link.dq;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank state: an activate in the same cycle wins over a close
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      bank_open_o <= 2'h0;
    else
    begin
      // auto close after the last beat
      if (rd_fire && rd_left_r == 4'h1 && rd_ap_r)
        bank_open_o[rd_bank_r] <= 1'b0;
      if (link.cmd_v && link.cmd_op == rtt_pkg::CMD_PRE)
        bank_open_o[link.cmd_bank] <= 1'b0;
      if (link.cmd_v && link.cmd_op == rtt_pkg::CMD_ACT)
        bank_open_o[link.cmd_bank] <= 1'b1;
    end
  end

endmodule // rtt_dram
`default_nettype wire

// ### rtt_assertions.sv
// rtt_assertions: link timing checks
// assumes one clock; mode follows mode-register commands
`timescale 1ns/10ps
`default_nettype none
module rtt_assertions (
  input wire logic              clk_i,    // clock
  input wire logic              rst_n_i,  // reset, active low
  input wire logic              cmd_v,    // command valid
  input wire rtt_pkg::rtt_cmd_t cmd_op,   // command code
  input wire logic              cmd_bank, // bank
  input wire logic [12:0]       cmd_addr, // address
  input wire logic              dq_c_oe,  // controller enable
  input wire logic              dq_d_oe   // device enable
);
  logic [1:0] bl_r, als_r;
  logic [4:0] cl_r;
  logic [3:0] cwl_r;
  logic       rbs_r, wbs_r;
  logic [7:0] rc_r, wc_r, rb_r, wb_r, al, rl, wl, rbt, wbt;
  logic [7:0] act_r [2], pre_r [2], rd_r [2];

  // counters saturate so that an old command never wraps into a false hit
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mode follows each mode-register command seen on the link
  always_ff @(posedge clk_i)
    if (!rst_n_i)
    begin
      bl_r  <= rtt_pkg::RST_BL;
      cl_r  <= rtt_pkg::RST_CL;
      als_r <= rtt_pkg::RST_AL;
      cwl_r <= rtt_pkg::RST_CWL;
    end
    else if (cmd_v && cmd_op == rtt_pkg::CMD_MRS)
    begin
      bl_r  <= cmd_addr[1:0];
      cl_r  <= cmd_addr[6:2];
      als_r <= cmd_addr[8:7];
      cwl_r <= cmd_addr[12:9];
    end

  // latencies and burst sizes expected from the mode
  assign al  = (als_r == 2'h1) ? 8'(cl_r) - 8'h01 : (als_r == 2'h2) ? 8'(cl_r) - 8'h02 : 8'h00;
  assign rl  = 8'(cl_r) + al;
  assign wl  = 8'(cwl_r) + al;
  assign rbt = (bl_r == rtt_pkg::BL_FIX8 || (bl_r == rtt_pkg::BL_OTF && rbs_r)) ? 8'h08 : 8'h04;
  assign wbt = (bl_r == rtt_pkg::BL_FIX8 || (bl_r == rtt_pkg::BL_OTF && wbs_r)) ? 8'h08 : 8'h04;

  // cycles since the last read and write, and per-bank command ages
  always_ff @(posedge clk_i)
    if (!rst_n_i)
    begin
      rc_r <= 8'hFF;
      wc_r <= 8'hFF;
    end
    else
    begin
      rc_r <= (cmd_v && cmd_op == rtt_pkg::CMD_RD) ? 8'h01 : inc(rc_r);
      wc_r <= (cmd_v && cmd_op == rtt_pkg::CMD_WR) ? 8'h01 : inc(wc_r);
    end
  always_ff @(posedge clk_i)
    for (int b = 0; b < 2; b++)
      if (!rst_n_i)
      begin
        act_r[b] <= 8'hFF;
        pre_r[b] <= 8'hFF;
        rd_r[b]  <= 8'hFF;
      end
      else
      begin
        act_r[b] <= (cmd_v && cmd_op == rtt_pkg::CMD_ACT && cmd_bank == 1'(b)) ? 8'h01 : inc(act_r[b]);
        pre_r[b] <= (cmd_v && cmd_op == rtt_pkg::CMD_PRE && cmd_bank == 1'(b)) ? 8'h01 : inc(pre_r[b]);
        rd_r[b]  <= (cmd_v && cmd_op == rtt_pkg::CMD_RD && cmd_bank == 1'(b)) ? 8'h01 : inc(rd_r[b]);
      end

  // beats of the running bursts and the burst select of each read and write command
  always_ff @(posedge clk_i)
  begin
    rb_r <= dq_d_oe ? rb_r + 8'h01 : 8'h00;
    wb_r <= dq_c_oe ? wb_r + 8'h01 : 8'h00;
    if (cmd_v && cmd_op == rtt_pkg::CMD_RD) rbs_r <= cmd_addr[rtt_pkg::A_BSEL];
    if (cmd_v && cmd_op == rtt_pkg::CMD_WR) wbs_r <= cmd_addr[rtt_pkg::A_BSEL];
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_cmd(rtt_pkg::rtt_cmd_t op);
    cmd_v && cmd_op == op;
  endsequence

  AST_RD_LAT: assert property ($rose(dq_d_oe) |-> rc_r == rl)
    else $error("read data off its latency");
  AST_RD_BEATS: assert property ($fell(dq_d_oe) |-> rb_r == rbt)
    else $error("read burst length wrong");
  AST_WR_LAT: assert property ($rose(dq_c_oe) |-> wc_r == wl)
    else $error("write data off its latency");
  AST_WR_BEATS: assert property ($fell(dq_c_oe) |-> wb_r == wbt)
    else $error("write burst length wrong");
  AST_TURN: assert property (dq_d_oe |-> !dq_c_oe ##1 !dq_c_oe)
    else $error("write data meets read data");
  AST_RTP: assert property (s_cmd(rtt_pkg::CMD_PRE) |-> rd_r[cmd_bank] >= al + 8'(rtt_pkg::N_RTP))
    else $error("close too soon after read");
  AST_RAS: assert property (s_cmd(rtt_pkg::CMD_PRE) |-> act_r[cmd_bank] >= 8'(rtt_pkg::N_RAS))
    else $error("close too soon after open");
  AST_RP: assert property (s_cmd(rtt_pkg::CMD_ACT) |-> pre_r[cmd_bank] >= 8'(rtt_pkg::N_RP))
    else $error("open too soon after close");
  AST_RC: assert property (s_cmd(rtt_pkg::CMD_ACT) |-> act_r[cmd_bank] >= 8'(rtt_pkg::N_RC))
    else $error("open too soon after open");
endmodule // rtt_assertions
`default_nettype wire

// ### read_turnaround_timing_tb.sv
// read_turnaround_timing_tb: both ends joined, driven by registers
// assumes the register map and single-rate link
`timescale 1ns/10ps
`default_nettype none
module read_turnaround_timing_tb;
  logic        clk_i, rst_n_i, reg_wr_i, reg_rd_i, rd_ready_i, rd_valid_o;
  logic [7:0]  reg_addr_i, rd_data_o, tick;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic [1:0]  bank_open_o;
  logic [7:0]  rq [$];
  int          mismatches, num_checks;

  rtt_if rtt_if_inst ();
  rtt_dram rtt_dram_inst (.link(rtt_if_inst), .*);
  rtt_ctrl rtt_ctrl_inst (.link(rtt_if_inst), .*);
  rtt_assertions rtt_assertions_inst (.clk_i, .rst_n_i,
    .cmd_v(rtt_if_inst.cmd_v), .cmd_op(rtt_if_inst.cmd_op), .cmd_bank(rtt_if_inst.cmd_bank),
    .cmd_addr(rtt_if_inst.cmd_addr), .dq_c_oe(rtt_if_inst.dq_c_oe),
    .dq_d_oe(rtt_if_inst.dq_d_oe));

  ////////////////////////////////////////////////////////////////////////
  // clock, reader, collector
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // reader stalls half the time so the buffer must hold words back
  always @(posedge clk_i)
  begin
    tick       <= tick + 8'h01;
    rd_ready_i <= tick[2];
  end
  // sampled mid-cycle, where the handshake is settled
  always @(negedge clk_i)
    if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
      rq.push_back(rd_data_o);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // orders are dropped unless idle
  task automatic idle();
    int n;
    n = 0;
    d = 32'h1;
    while (d[1:0] !== 2'h0 && n < 300)
    begin
      reg_rd(rtt_pkg::REG_STAT);
      n++;
    end
    if (n == 300)
      mismatches++;
  endtask
  task automatic cmd(input logic [2:0] op, input logic b = 1'b0, input logic [2:0] c = 3'h0,
                     input logic bs = 1'b0, input logic ap = 1'b0);
    reg_wr(rtt_pkg::REG_CMD, {23'h0, ap, bs, c, b, op});
    idle();
  endtask
  task automatic cfg(input logic [1:0] bl, input logic [1:0] als, input logic p2);
    reg_wr(rtt_pkg::REG_CFG, {18'h0, p2, rtt_pkg::CWL_MIN, als, 5'h0B, bl});
    idle();
  endtask
  // memory holds seed plus column after a full write
  task automatic rd_chk(input logic [2:0] c, input logic bs, input logic ap,
                        input logic [7:0] s, input int n);
    int k;
    repeat (30) @(posedge clk_i);
    rq.delete();
    cmd(rtt_pkg::CMD_RD, 1'b0, c, bs, ap);
    k = 0;
    while (rq.size() < n && k < 200)
    begin
      @(posedge clk_i);
      k++;
    end
    repeat (20) @(posedge clk_i);
    chk32("read count", 32'(n), 32'(rq.size()));
    for (int i = 0; i < rq.size(); i++)
      chk32("read word", 32'(s + {5'h0, 3'(c + i)}), 32'(rq[i]));
  endtask
  task automatic test_done();
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (30000) @(posedge clk_i);
    mismatches++;
    test_done();
  end
  initial
  begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    rd_ready_i = 1'b0;
    tick = 8'h00;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    reg_rd(8'h10);
    chk32("unmapped", 32'h0, d);
    cfg(rtt_pkg::BL_OTF, 2'h2, 1'b0);
    cmd(rtt_pkg::CMD_ACT);
    reg_wr(rtt_pkg::REG_WDATA, 32'h10);
    cmd(rtt_pkg::CMD_WR, 1'b0, 3'h0, 1'b1);
    rd_chk(3'h0, 1'b1, 1'b0, 8'h10, 8);
    chk32("bank kept", 32'h1, 32'(bank_open_o));
    rd_chk(3'h6, 1'b0, 1'b0, 8'h10, 4);
    for (int m = 0; m < 3; m++)
    begin
      cfg(2'(m), 2'h0, 1'b0);
      rd_chk(3'h3, 1'b0, 1'b0, 8'h10, (m == 0) ? 8 : 4);
    end
    cfg(rtt_pkg::BL_OTF, 2'h1, 1'b1);
    reg_rd(rtt_pkg::REG_STAT);
    chk32("cwl raised", 32'h1, 32'(d[2]));
    reg_wr(rtt_pkg::REG_WDATA, 32'h20);
    cmd(rtt_pkg::CMD_RD, 1'b0, 3'h4);
    cmd(rtt_pkg::CMD_WR, 1'b0, 3'h0, 1'b1);
    rd_chk(3'h0, 1'b1, 1'b1, 8'h20, 8);
    chk32("bank closed", 32'h0, 32'(bank_open_o));
    cmd(rtt_pkg::CMD_ACT);
    cmd(rtt_pkg::CMD_PRE);
    cmd(rtt_pkg::CMD_ACT);
    cmd(rtt_pkg::CMD_ACT, 1'b1);
    chk32("banks open", 32'h3, 32'(bank_open_o));
    cmd(rtt_pkg::CMD_RD, 1'b0, 3'h0, 1'b1);
    cmd(rtt_pkg::CMD_PRE);
    repeat (40) @(posedge clk_i);
    chk32("bank0 closed", 32'h2, 32'(bank_open_o));
    test_done();
  end
endmodule // read_turnaround_timing_tb
`default_nettype wire
